// [design/btt_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// Eight-word capture buffer, oldest entry out first
module btt_fifo (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic push,
  input wire btt_pkg::btt_entry_t push_data,
  input wire logic pop,
  output btt_pkg::btt_entry_t head,
  output logic empty,
  output logic full,
  output logic [btt_pkg::CNT_W-1:0] count
);
  import btt_pkg::*;

  btt_entry_t mem [DEPTH]; // Storage array
  logic [PTR_W-1:0] wr_ptr; // Next free slot
  logic [PTR_W-1:0] rd_ptr; // Oldest entry
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic do_push;
  logic do_pop;

  // Push is dropped when full so the oldest entries survive
  always_comb begin
    do_push = push && (count != CNT_W'(DEPTH));
    do_pop = pop && (count != CNT_RESET);
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (clear) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = CNT_RESET;
    end else begin
      if (do_push) begin
        next_wr_ptr = wr_ptr + PTR_W'(1);
      end
      if (do_pop) begin
        next_rd_ptr = rd_ptr + PTR_W'(1);
      end
      next_count = count + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= CNT_RESET;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage write; no reset needed for the array
  always_ff @(posedge clk) begin
    if (ce && do_push && !clear) begin
      mem[wr_ptr] <= push_data;
    end
  end

  assign head = mem[rd_ptr];
  assign empty = (count == CNT_RESET);
  assign full = (count == CNT_W'(DEPTH));
endmodule : btt_fifo
`default_nettype wire

// [design/btt_unit.sv]
// Contract
// - two comparators and eight-word capture buffer
// - A on address; B address or data
// - nine modes pick trigger and capture kind
// - A only: address equals A
// - A or B: address equals either; the code compares data with B when b_on_data is set
// - A then B: B after A
// - address A and data equals B
// - address A and data differs B
// - event B: store data each B hit
// - event B data only after A hit
// - inside range: A to B inclusive
// - outside range: below A or above B
// - flow capture stores only flow breaks
// - capture never stalls the processor
// - buffer readable through debug controller
// - host uses single dedicated debug pin
`timescale 1ns/1ps
`default_nettype none
module btt_unit (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire btt_pkg::btt_access_t BUS,
  input wire btt_pkg::btt_ctrl_t CTRL,
  input wire logic READ_REQ,
  output btt_pkg::btt_entry_t READ_DATA,
  output logic READ_VALID,
  output logic TRIGGERED,
  output logic ARMED,
  output logic FULL,
  output logic [btt_pkg::CNT_W-1:0] COUNT
);
  import btt_pkg::*;

  // Comparator outputs
  logic hit_a;
  logic hit_b_addr;
  logic hit_b_data;
  logic hit_b;
  logic in_range;
  // Sequence and trigger state
  logic seen_a; // A has matched first
  logic next_seen_a;
  logic trig; // Trigger has fired
  logic next_trig;
  logic next_armed;
  logic fire; // Trigger condition this access
  logic data_mode; // Event-only modes store data
  logic arm_q; // Previous arm level
  logic arm_rise;
  // Buffer interface
  logic push;
  btt_entry_t push_data;
  logic pop;
  logic fifo_empty;
  btt_entry_t fifo_head;
  btt_entry_t next_read_data;
  logic next_read_valid;

  // Address matches one-to-one; B follows its address/data select
  function automatic logic eq_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    eq_addr = (a == b);
  endfunction : eq_addr

  // Comparators, pure combinational so observing adds no wait states
  always_comb begin
    hit_a = BUS.valid && eq_addr(BUS.addr, CTRL.cmp_a);
    hit_b_addr = BUS.valid && eq_addr(BUS.addr, CTRL.cmp_b);
    hit_b_data = BUS.valid && (BUS.data == CTRL.cmp_b[DATA_W-1:0]);
    hit_b = CTRL.b_on_data ? hit_b_data : hit_b_addr;
    in_range = BUS.valid && (BUS.addr >= CTRL.cmp_a) && (BUS.addr <= CTRL.cmp_b);
  end

  // Mode decode of the trigger condition
  always_comb begin
    fire = 1'b0;
    data_mode = 1'b0;
    case (CTRL.mode)
      MODE_A_ONLY: begin
        fire = hit_a;
      end
      MODE_A_OR_B: begin
        // B follows its address/data select here; the bench keeps it on address
        fire = hit_a || hit_b;
      end
      MODE_A_THEN_B: begin
        fire = seen_a && hit_b_addr;
      end
      MODE_A_AND_B_DATA: begin
        fire = hit_a && hit_b_data;
      end
      MODE_A_AND_NOT_B_DATA: begin
        fire = hit_a && !hit_b_data;
      end
      MODE_EVENT_B: begin
        fire = hit_b_addr;
        data_mode = 1'b1;
      end
      MODE_A_THEN_EVENT_B: begin
        fire = seen_a && hit_b_addr;
        data_mode = 1'b1;
      end
      MODE_INSIDE: begin
        fire = in_range;
      end
      MODE_OUTSIDE: begin
        // Strictly below A or above B
        fire = BUS.valid && !in_range;
      end
      default: begin
        fire = 1'b0;
      end
    endcase
  end

  // Sequence and trigger next state; rearm restarts everything
  always_comb begin
    arm_rise = CTRL.arm && !arm_q;
    next_armed = CTRL.arm;
    next_seen_a = seen_a;
    next_trig = trig;
    if (arm_rise || !CTRL.arm) begin
      next_seen_a = 1'b0;
      next_trig = 1'b0;
    end else begin
      if (hit_a) begin
        next_seen_a = 1'b1;
      end
      if (fire) begin
        next_trig = 1'b1;
      end
    end
  end

  // Capture decision: data modes store each event, flow modes store breaks
  always_comb begin
    push = 1'b0;
    push_data = '0;
    if (ARMED && CTRL.arm && !arm_rise) begin
      if (data_mode) begin
        push = fire;
        push_data.is_data = 1'b1;
        push_data.word = {{(ADDR_W-DATA_W){1'b0}}, BUS.data};
      end else begin
        // Flow mode records from the triggering access onward, on flow breaks only
        push = (trig || fire) && BUS.valid && BUS.cof;
        push_data.is_data = 1'b0;
        push_data.word = BUS.addr;
      end
    end
  end

  // Read port: one-cycle answer with the oldest entry, which is removed
  always_comb begin
    pop = READ_REQ && !fifo_empty;
    next_read_valid = pop;
    next_read_data = pop ? fifo_head : READ_DATA;
  end

  // State registers; CE freezes all of it
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      seen_a <= 1'b0;
      trig <= 1'b0;
      ARMED <= 1'b0;
      arm_q <= 1'b0;
      READ_VALID <= 1'b0;
      READ_DATA <= '0;
    end else if (CE) begin
      seen_a <= next_seen_a;
      trig <= next_trig;
      ARMED <= next_armed;
      arm_q <= CTRL.arm;
      READ_VALID <= next_read_valid;
      READ_DATA <= next_read_data;
    end
  end

  assign TRIGGERED = trig;

  // Buffer, cleared on rearm; pushes never back-pressure the bus
  btt_fifo u_fifo (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .clear(arm_rise),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .full(FULL),
    .count(COUNT)
  );

  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  chk_full_count: assert property (FULL == (COUNT == CNT_W'(DEPTH)))
    else $error("full flag disagrees with count");
  chk_full_holds: assert property (CE && FULL && !pop && !arm_rise |=> FULL)
    else $error("full cleared without read or rearm");
  chk_read_answer: assert property (CE && READ_REQ && !fifo_empty |=> READ_VALID)
    else $error("read not answered next cycle");
  chk_read_idle: assert property (CE && !READ_REQ |=> !READ_VALID)
    else $error("read valid without request");
  chk_pop_count: assert property (CE && pop && !push && !arm_rise |=> COUNT == $past(COUNT) - 1)
    else $error("read did not remove entry");
  chk_flow_only: assert property (push && !data_mode |-> BUS.cof)
    else $error("sequential access captured");
  chk_a_only: assert property (CTRL.mode == MODE_A_ONLY && BUS.valid |-> fire == (BUS.addr == CTRL.cmp_a))
    else $error("A only trigger wrong");
  chk_then_b: assert property (CTRL.mode == MODE_A_THEN_B && !seen_a |-> !fire)
    else $error("B fired before A");
  chk_then_ev: assert property (CTRL.mode == MODE_A_THEN_EVENT_B && !seen_a |-> !push)
    else $error("event stored before A");
  chk_outside: assert property (CTRL.mode == MODE_OUTSIDE && BUS.valid && BUS.addr == CTRL.cmp_a && CTRL.cmp_a <= CTRL.cmp_b |-> !fire)
    else $error("outside fired on bound");
  cov_full: cover property (CE && FULL);
  cov_event: cover property (push && data_mode);
  cov_then: cover property (CTRL.mode == MODE_A_THEN_B && fire);
  cov_read: cover property (READ_VALID);
endmodule : btt_unit
`default_nettype wire

// [include/btt_pkg.sv]
package btt_pkg;
  // Bus widths of the observed processor buses
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Capture buffer depth, eight words
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  // Reset values
  localparam logic [ADDR_W-1:0] CMP_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  // Trigger modes; the nine documented selections
  typedef enum logic [3:0] {
    MODE_A_ONLY,
    MODE_A_OR_B,
    MODE_A_THEN_B,
    MODE_A_AND_B_DATA,
    MODE_A_AND_NOT_B_DATA,
    MODE_EVENT_B,
    MODE_A_THEN_EVENT_B,
    MODE_INSIDE,
    MODE_OUTSIDE
  } btt_mode_t;
  // One observed bus access
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic cof;
  } btt_access_t;
  // Control from the background debug controller
  typedef struct packed {
    logic arm;
    btt_mode_t mode;
    logic [ADDR_W-1:0] cmp_a;
    logic [ADDR_W-1:0] cmp_b;
    logic b_on_data;
  } btt_ctrl_t;
  // One captured buffer word: address or data
  typedef struct packed {
    logic is_data;
    logic [ADDR_W-1:0] word;
  } btt_entry_t;
endpackage : btt_pkg

// [tb/btt_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Processor bus under observation; it has no wait input, so it never stalls
module btt_bus_model (
  input wire logic clk,
  input wire logic req_valid,
  input wire logic [btt_pkg::ADDR_W-1:0] req_addr,
  input wire logic [btt_pkg::DATA_W-1:0] req_data,
  input wire logic req_cof,
  output btt_pkg::btt_access_t bus
);
  import btt_pkg::*;
  logic [ADDR_W-1:0] last_addr = '0; // Last address put on the bus
  logic [DATA_W-1:0] last_data = '0; // Last data put on the bus
  // Remember the last access so idle cycles can show something else
  always @(posedge clk) begin
    if (req_valid) begin
      last_addr <= req_addr;
      last_data <= req_data;
    end
  end
  // Idle cycles show inverted values, so a stale access cannot match by luck
  always_comb begin
    bus.valid = req_valid;
    bus.addr = req_valid ? req_addr : ~last_addr;
    bus.data = req_valid ? req_data : ~last_data;
    bus.cof = req_valid & req_cof;
  end
endmodule : btt_bus_model
`default_nettype wire

// [tb/tb_btt_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_btt_unit;
  import btt_pkg::*;
  logic clk, arst_n, ce, read_req, rd_valid, trig, armed, full; // Bench side of the unit
  logic r_valid, r_cof; // Access request to the bus model
  logic [ADDR_W-1:0] r_addr, a; // Request address and scratch address
  logic [DATA_W-1:0] r_data, d; // Request data and scratch data
  logic [CNT_W-1:0] count;
  btt_access_t bus;
  btt_ctrl_t ctrl;
  btt_entry_t rd_data;
  int fail_count = 0;
  int cmp_count = 0;
  integer seed = 32'h73D49BDF; // Fixed seed keeps runs repeatable
  logic [ADDR_W-1:0] pool [6]; // Addresses around the comparator edges
  btt_entry_t q[$]; // Expected buffer, oldest first
  logic exp_seen, exp_trig; // Expected first-match and trigger state
  btt_bus_model i_btt_bus_model (.clk(clk), .req_valid(r_valid), .req_addr(r_addr),
    .req_data(r_data), .req_cof(r_cof), .bus(bus));
  btt_unit i_btt_unit (.CLK(clk), .ARST_N(arst_n), .CE(ce), .BUS(bus), .CTRL(ctrl),
    .READ_REQ(read_req), .READ_DATA(rd_data), .READ_VALID(rd_valid), .TRIGGERED(trig),
    .ARMED(armed), .FULL(full), .COUNT(count));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Verdict and end of run
  task automatic end_sim();
    $display("TB: compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // Shared tally for every compare
  function automatic void note(input logic bad, input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (bad) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endfunction : note
  task automatic chk_bit(input logic got, input logic exp);
    note(got !== exp, {16'h0000, got}, {16'h0000, exp});
  endtask : chk_bit
  task automatic chk_cnt(input logic [CNT_W-1:0] got, input int exp);
    note(got !== CNT_W'(exp), {13'h0000, got}, 17'(exp));
  endtask : chk_cnt
  task automatic chk_ent(input btt_entry_t got, input btt_entry_t exp);
    note(got !== exp, got, exp);
  endtask : chk_ent
  // Trigger condition of the selected mode
  function automatic logic fire(input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] y);
    case (ctrl.mode)
      MODE_A_ONLY: return x == ctrl.cmp_a;
      MODE_A_OR_B: return x == ctrl.cmp_a || x == ctrl.cmp_b;
      MODE_A_THEN_B: return exp_seen && x == ctrl.cmp_b;
      MODE_A_AND_B_DATA: return x == ctrl.cmp_a && y == ctrl.cmp_b[7:0];
      MODE_A_AND_NOT_B_DATA: return x == ctrl.cmp_a && y != ctrl.cmp_b[7:0];
      MODE_EVENT_B: return x == ctrl.cmp_b;
      MODE_A_THEN_EVENT_B: return exp_seen && x == ctrl.cmp_b;
      MODE_INSIDE: return x >= ctrl.cmp_a && x <= ctrl.cmp_b;
      MODE_OUTSIDE: return x < ctrl.cmp_a || x > ctrl.cmp_b;
      default: return 1'b0;
    endcase
  endfunction : fire
  // Expected effect of one access taken at the coming edge
  task automatic model(input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] y, input logic c);
    logic f;
    logic ev;
    f = fire(x, y);
    ev = ctrl.mode inside {MODE_EVENT_B, MODE_A_THEN_EVENT_B};
    // A full buffer drops the capture silently
    if (q.size() < DEPTH) begin
      if (ev && f) begin
        q.push_back({1'b1, 8'h00, y});
      end else if (!ev && c && (exp_trig || f)) begin
        q.push_back({1'b0, x});
      end
    end
    exp_trig = exp_trig | f;
    exp_seen = exp_seen | (x == ctrl.cmp_a);
  endtask : model
  // One access per cycle; valid stays up so accesses run back to back
  task automatic acc(input logic [ADDR_W-1:0] x, input logic [DATA_W-1:0] y, input logic c);
    r_valid = 1'b1;
    r_addr = x;
    r_data = y;
    r_cof = c;
    model(x, y, c);
    @(negedge clk);
    chk_cnt(count, q.size());
    chk_bit(full, q.size() == DEPTH);
    chk_bit(trig, exp_trig);
  endtask : acc
  task automatic idle();
    r_valid = 1'b0;
    @(negedge clk);
  endtask : idle
  // Held read request; the last cycles hit an empty buffer
  task automatic drain(input int n);
    read_req = 1'b1;
    repeat (n) begin
      @(negedge clk);
      chk_bit(rd_valid, q.size() != 0);
      if (q.size() != 0) begin
        chk_ent(rd_data, q.pop_front());
      end
      chk_cnt(count, q.size());
    end
    read_req = 1'b0;
  endtask : drain
  // Drop arm for a cycle, then raise it: buffer and trigger start afresh
  task automatic rearm(input btt_mode_t m);
    ctrl.arm = 1'b0;
    @(negedge clk);
    chk_bit(armed, 1'b0);
    ctrl.mode = m;
    ctrl.b_on_data = m inside {MODE_A_AND_B_DATA, MODE_A_AND_NOT_B_DATA};
    ctrl.arm = 1'b1;
    @(negedge clk);
    q.delete();
    exp_seen = 1'b0;
    exp_trig = 1'b0;
    chk_bit(armed, 1'b1);
    chk_cnt(count, 0);
  endtask : rearm
  // Hang guard
  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    read_req = 1'b0;
    {r_valid, r_cof, r_addr, r_data} = '0;
    ctrl = '0;
    ctrl.cmp_a = 16'h2000;
    ctrl.cmp_b = 16'h2010;
    pool = '{16'h2000, 16'h2010, 16'h1FFF, 16'h2011, 16'h2008, 16'h0000};
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk_cnt(count, 0);
    // Every mode with random traffic around the comparator edges
    for (int m = 0; m < 9; m++) begin
      rearm(btt_mode_t'(m));
      repeat (24) begin
        pool[5] = ADDR_W'($random(seed));
        a = pool[$unsigned($random(seed)) % 6];
        d = ($random(seed) & 3) == 0 ? 8'h10 : DATA_W'($random(seed));
        acc(a, d, 1'($random(seed)));
      end
      idle();
      drain(DEPTH + 1);
      $display("TB: mode %0d done", m);
    end
    // Overfill: the last captures must be dropped
    rearm(MODE_A_ONLY);
    repeat (DEPTH + 2) acc(16'h2000, 8'h5A, 1'b1);
    idle();
    // Clock enable low freezes the buffer against reads
    ce = 1'b0;
    read_req = 1'b1;
    @(negedge clk);
    read_req = 1'b0;
    ce = 1'b1;
    chk_bit(rd_valid, 1'b0);
    chk_cnt(count, DEPTH);
    rearm(MODE_A_ONLY);
    $display("TB: full and rearm done");
    end_sim();
  end
endmodule : tb_btt_unit
`default_nettype wire
